// ### core/rcbr_top.sv
// top: strap capture, internal reset generation, clock source and bus routing register
`timescale 1ns/1ps
module rcbr_top (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // straps and monitor
    input wire logic core_regulator_enable_pin_i,
    input wire logic clk_source_select_pin_i,
    input wire logic supply_monitor_ok_i,
    input wire logic reset_pin_released_i,
    // cpu port access
    input wire rcbr_pkg::rcbr_port_s port_i,
    output logic [15:0] port_rdata_o,
    output logic port_rvalid_o,
    // regulator and clock control
    output logic core_regulator_on_o,
    output logic core_regulator_v_low_o,
    output logic supply_good_o,
    output logic device_reset_o,
    output logic sysclk_from_external_o,
    output logic rtc_from_osc_o,
    // routing
    output rcbr_pkg::rcbr_route_s route_o
);
    import rcbr_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] pins_s;

    rcbr_sync2 #(.W(4)) u_sync (
        .mclk_i(mclk_i),
        .d_i({core_regulator_enable_pin_i, clk_source_select_pin_i,
              supply_monitor_ok_i, reset_pin_released_i}),
        .q_o(pins_s)
    );

    wire ldo_en_pin_s = pins_s[3];
    wire clk_sel_pin_s = pins_s[2];
    wire mon_ok_s = pins_s[1];
    wire rst_rel_s = pins_s[0];

    // ************************************************************
    // strap capture
    // ************************************************************
    // straps are latched while reset holds; a change later is ignored until the
    // next reset, which is why the board must reset after restrapping
    logic ldo_off_strap_r;
    logic clk_ext_strap_r;
    rcbr_state_e state_r;
    rcbr_state_e state_nxt;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || state_r == RCBR_ST_HOLD)
        begin
            ldo_off_strap_r <= ldo_en_pin_s;
            clk_ext_strap_r <= clk_sel_pin_s;
        end
    end

    // ************************************************************
    // supply good and internal reset
    // ************************************************************
    // bypassed monitor forces good, else follow the monitor
    wire supply_good_w = ldo_off_strap_r | mon_ok_s;
    wire reset_release_w = supply_good_w & rst_rel_s;

    assign state_nxt = reset_release_w ? RCBR_ST_RUN : RCBR_ST_HOLD;

    // sequencer: any loss of good or reset pin drops back to hold
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            state_r <= RCBR_ST_HOLD;
        else
        begin
            case (state_r)
                RCBR_ST_HOLD: state_r <= state_nxt;
                RCBR_ST_RUN: state_r <= state_nxt;
                default: state_r <= RCBR_ST_HOLD;
            endcase
        end
    end

    // ************************************************************
    // regulator voltage select
    // ************************************************************
    logic ldo_v_low_r;
    wire ldo_ctrl_wr_w = port_i.wr && port_i.addr == RCBR_LDO_CTRL_ADDR;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            ldo_v_low_r <= 1'b0; // 1.3 V after reset
        else if (ldo_ctrl_wr_w)
            ldo_v_low_r <= port_i.wdata[RCBR_LDO_V_BIT];
    end

    // ************************************************************
    // bus selection register
    // ************************************************************
    rcbr_route_s route_r;
    wire ebsel_hit_w = port_i.addr == RCBR_EBSEL_ADDR;
    wire ebsel_wr_w = port_i.wr && ebsel_hit_w;
    // reserved codes are stored as written and read back unchanged
    wire rcbr_route_s route_nxt = '{pp: rcbr_pp_e'(port_i.wdata[RCBR_PP_LSB +: 3]),
                                    sp1: rcbr_sp_e'(port_i.wdata[RCBR_SP1_LSB +: 2]),
                                    sp0: rcbr_sp_e'(port_i.wdata[RCBR_SP0_LSB +: 2])};

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            route_r <= RCBR_ROUTE_RST;
        else if (ebsel_wr_w)
            route_r <= route_nxt;
    end

    // read data: reserved bits zero
    wire [15:0] ebsel_rd_w = RCBR_RSVD_ZERO | {1'b0, route_r, 8'h00};
    wire [15:0] ldo_rd_w = RCBR_RSVD_ZERO | (16'(ldo_v_low_r) << RCBR_LDO_V_BIT);
    wire [15:0] rd_mux_w = ebsel_hit_w ? ebsel_rd_w :
                           (port_i.addr == RCBR_LDO_CTRL_ADDR) ? ldo_rd_w : RCBR_RSVD_ZERO;

    // ************************************************************
    // registered outputs
    // ************************************************************
    // everything leaves through flops; routing appears the cycle after the write
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            port_rdata_o <= RCBR_RSVD_ZERO;
            port_rvalid_o <= 1'b0;
            core_regulator_on_o <= 1'b0;
            core_regulator_v_low_o <= 1'b0;
            supply_good_o <= 1'b0;
            device_reset_o <= 1'b1;
            sysclk_from_external_o <= 1'b0;
            rtc_from_osc_o <= 1'b1;
            route_o <= RCBR_ROUTE_RST;
        end
        else
        begin
            port_rdata_o <= port_i.rd ? rd_mux_w : RCBR_RSVD_ZERO;
            port_rvalid_o <= port_i.rd;
            core_regulator_on_o <= ~ldo_off_strap_r;
            // follow the write at the same edge that stores it, like the routing
            core_regulator_v_low_o <= ldo_ctrl_wr_w ? port_i.wdata[RCBR_LDO_V_BIT] : ldo_v_low_r;
            supply_good_o <= supply_good_w;
            device_reset_o <= ~reset_release_w;
            sysclk_from_external_o <= clk_ext_strap_r;
            rtc_from_osc_o <= 1'b1;
            route_o <= ebsel_wr_w ? route_nxt : route_r;
        end
    end
endmodule

// ### core/rcbr_pkg.sv
// package: constants and types of the reset configuration and bus routing block
package rcbr_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] RCBR_EBSEL_ADDR = 16'h1C00;
    localparam int RCBR_PP_LSB = 12;
    localparam int RCBR_SP1_LSB = 10;
    localparam int RCBR_SP0_LSB = 8;
    localparam logic [15:0] RCBR_RSVD_ZERO = 16'h0000;
    localparam logic [15:0] RCBR_LDO_CTRL_ADDR = 16'h7004;
    localparam int RCBR_LDO_V_BIT = 1;

    // ************************************************************
    // routing encodings
    // ************************************************************
    typedef enum logic [2:0] {
        RCBR_PP_LCD16 = 3'h0,
        RCBR_PP_SPI_GPIO_UART_AUD2 = 3'h1,
        RCBR_PP_LCD8_GPIO = 3'h2,
        RCBR_PP_LCD8_SPI_AUD3 = 3'h3,
        RCBR_PP_LCD8_AUD2_UART = 3'h4,
        RCBR_PP_LCD8_SPI_UART = 3'h5,
        RCBR_PP_SPI_AUD2_AUD3_GPIO = 3'h6,
        RCBR_PP_RSVD = 3'h7
    } rcbr_pp_e;

    typedef enum logic [1:0] {
        RCBR_SP_CARD = 2'h0,
        RCBR_SP_AUD_GPIO = 2'h1,
        RCBR_SP_GPIO = 2'h2,
        RCBR_SP_RSVD = 2'h3
    } rcbr_sp_e;

    // routing fields as one carrier
    typedef struct packed {
        rcbr_pp_e pp;
        rcbr_sp_e sp1;
        rcbr_sp_e sp0;
    } rcbr_route_s;

    localparam rcbr_route_s RCBR_ROUTE_RST = '{pp: RCBR_PP_LCD16, sp1: RCBR_SP_CARD,
                                               sp0: RCBR_SP_CARD};

    // reset sequencer states
    typedef enum logic [1:0] {
        RCBR_ST_HOLD = 2'h0,
        RCBR_ST_RUN = 2'h1
    } rcbr_state_e;

    // port access carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rcbr_port_s;
endpackage

// ### core/rcbr_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rcbr_sync2 #(
    parameter int W = 1
) (
    // clock
    input wire logic mclk_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge mclk_i)
    begin
        meta_r <= d_i;
        q_o <= meta_r;
    end
endmodule

// ### testbench/rcbr_board.sv
// board model: strap resistors, supply monitor pacing and external reset pin
`timescale 1ns/1ps
module rcbr_board (
    // clock and board reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // strap settings and pacing
    input wire logic ldo_cfg_i,
    input wire logic clk_cfg_i,
    input wire logic late_mon_i,
    // pins seen by the device
    output logic ldo_pin_o,
    output logic clk_pin_o,
    output logic mon_ok_o,
    output logic rel_o
);
    logic [3:0] cnt_r;
    // straps move only under reset, so they never change in operation
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ldo_pin_o <= ldo_cfg_i;
            clk_pin_o <= clk_cfg_i;
            cnt_r <= 4'h0;
        end
        else if (cnt_r != 4'hF)
            cnt_r <= cnt_r + 4'h1;
    end
    // an open regulator output never reaches threshold
    assign mon_ok_o = !ldo_pin_o && cnt_r >= (late_mon_i ? 4'hC : 4'h4);
    assign rel_o = cnt_r >= (late_mon_i ? 4'h4 : 4'hC);
endmodule

// ### testbench/rcbr_chk.sv
// checker: port-level assertions of the routing block
`timescale 1ns/1ps
module rcbr_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic core_regulator_enable_pin_i,
    input wire logic clk_source_select_pin_i,
    input wire logic reset_pin_released_i,
    input wire rcbr_pkg::rcbr_port_s port_i,
    input wire logic [15:0] port_rdata_o,
    input wire logic port_rvalid_o,
    input wire logic core_regulator_on_o,
    input wire logic core_regulator_v_low_o,
    input wire logic supply_good_o,
    input wire logic device_reset_o,
    input wire logic sysclk_from_external_o,
    input wire logic rtc_from_osc_o,
    input wire rcbr_pkg::rcbr_route_s route_o
);
    import rcbr_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire sel_wr = port_i.wr && port_i.addr == RCBR_EBSEL_ADDR;
    wire sel_rd = port_i.rd && !port_i.wr && port_i.addr == RCBR_EBSEL_ADDR;
    wire un_rd = port_i.rd && port_i.addr != RCBR_EBSEL_ADDR && port_i.addr != RCBR_LDO_CTRL_ADDR;
    route_update_a: assert property (sel_wr |=> route_o == $past(port_i.wdata[14:8]))
        else $error("route not taken from write");
    route_hold_a: assert property (!sel_wr |=> $stable(route_o))
        else $error("route moved without write");
    rsvd_zero_a: assert property (port_rvalid_o |-> port_rdata_o[15] == 1'b0 && port_rdata_o[7:0] == 8'h00)
        else $error("reserved bits not zero");
    sel_read_a: assert property (sel_rd |=> port_rvalid_o && port_rdata_o[14:8] == route_o)
        else $error("selection read wrong");
    unmapped_a: assert property (un_rd |=> port_rvalid_o && port_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    volt_sel_a: assert property (port_i.wr && port_i.addr == RCBR_LDO_CTRL_ADDR |=>
        core_regulator_v_low_o == $past(port_i.wdata[1]))
        else $error("voltage select not taken");
    rel_gate_a: assert property ($fell(device_reset_o) |-> supply_good_o && $past(reset_pin_released_i, 2))
        else $error("reset released early");
    bypass_good_a: assert property (!device_reset_o && !core_regulator_on_o |-> supply_good_o)
        else $error("supply good not forced");
    clk_src_a: assert property (!device_reset_o |-> sysclk_from_external_o == clk_source_select_pin_i && rtc_from_osc_o)
        else $error("clock source wrong");
    reg_on_a: assert property (!device_reset_o |-> core_regulator_on_o == !core_regulator_enable_pin_i)
        else $error("regulator state wrong");
endmodule
bind rcbr_top rcbr_chk u_chk (.*);

// ### testbench/tb.sv
// testbench: strap sweep, reset sequencing and selection register traffic
`timescale 1ns/1ps
module tb;
    import rcbr_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ldo_cfg = 1'b0, clk_cfg = 1'b0, late = 1'b0;
    logic core_regulator_enable_pin_i, clk_source_select_pin_i, supply_monitor_ok_i, reset_pin_released_i;
    rcbr_port_s port_i = '0;
    logic [15:0] port_rdata_o, exp_ebs, d, got;
    logic port_rvalid_o, core_regulator_on_o, core_regulator_v_low_o, supply_good_o;
    logic device_reset_o, sysclk_from_external_o, rtc_from_osc_o;
    rcbr_route_s route_o;
    integer errors = 0, n_compared = 0, seed = 16894, i, k, t;
    rcbr_top DUT (.*);
    rcbr_board u_board (.mclk_i(mclk_i), .rst_i(rst_i), .ldo_cfg_i(ldo_cfg), .clk_cfg_i(clk_cfg),
        .late_mon_i(late), .ldo_pin_o(core_regulator_enable_pin_i), .clk_pin_o(clk_source_select_pin_i),
        .mon_ok_o(supply_monitor_ok_i), .rel_o(reset_pin_released_i));
    always #25 mclk_i = ~mclk_i;
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_compared += 1;
        if (g !== e)
        begin
            errors += 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one strobe cycle; reads are taken the cycle after the strobe
    task acc(input logic w, input logic [15:0] a, input logic [15:0] wd);
        @(posedge mclk_i);
        port_i <= '{wr: w, rd: !w, addr: a, wdata: wd};
        @(posedge mclk_i);
        port_i <= '0;
        #1 got = port_rdata_o;
        if (!w) chk(port_rvalid_o, 1'b1);
    endtask
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ************************************************************
    // every strap pair, monitor late or early
    // ************************************************************
    initial
    begin
        for (i = 0; i < 8; i++)
        begin
            @(posedge mclk_i);
            rst_i <= 1'b1;
            {late, clk_cfg, ldo_cfg} <= i[2:0];
            repeat (16) @(posedge mclk_i);
            rst_i <= 1'b0;
            exp_ebs = 16'h0000;
            for (t = 0; device_reset_o !== 1'b0 && t < 200; t++)
            begin
                @(posedge mclk_i);
                #1;
            end
            if (t == 200) errors += 1;
            if (t == 200) end_sim;
            chk(t >= 12, late ? !ldo_cfg : 1'b1);
            chk({core_regulator_on_o, supply_good_o, sysclk_from_external_o, rtc_from_osc_o},
                {!ldo_cfg, 1'b1, clk_cfg, 1'b1});
            acc(1'b0, RCBR_EBSEL_ADDR, 16'h0000);
            chk(got, exp_ebs);
            // first write walks every code, then random words
            for (k = 0; k < 6; k++)
            begin
                d = (k == 0) ? {1'b1, i[2:0], i[1:0], i[1:0], 8'hFF} : 16'($random(seed));
                // no peripheral is clocked or used around these writes
                acc(1'b1, RCBR_EBSEL_ADDR, d);
                exp_ebs = d & 16'h7F00;
                chk({9'h000, route_o}, exp_ebs >> 8);
                acc(1'b0, RCBR_EBSEL_ADDR, 16'h0000);
                chk(got, exp_ebs);
            end
            acc(1'b1, RCBR_LDO_CTRL_ADDR, {14'h0000, i[0], 1'b0});
            chk(core_regulator_v_low_o, i[0]);
            acc(1'b1, 16'h1C01, 16'hFFFF);
            acc(1'b0, 16'h1C01, 16'h0000);
            chk(got, 16'h0000);
            chk({9'h000, route_o}, exp_ebs >> 8);
            $display("test %0d done", i);
        end
        end_sim;
    end
endmodule
